// File: src/fwsr_params.svh
`ifndef FWSR_PARAMS_SVH
`define FWSR_PARAMS_SVH

// Register offsets (byte addresses)
`define FWSR_OFF_CTRL    12'h000
`define FWSR_OFF_ADDR    12'h004
`define FWSR_OFF_EXPECT  12'h008
`define FWSR_OFF_STATUS  12'h00c

// Control fields
`define FWSR_CTRL_START  0
`define FWSR_CTRL_TOGGLE 1
`define FWSR_CTRL_ERASE  2

// Status fields
`define FWSR_ST_BUSY     0
`define FWSR_ST_DONE     1
`define FWSR_ST_FAIL     2
`define FWSR_ST_RECHECK  3
`define FWSR_ST_BYTE_LO  8

// Flash data bit positions
`define FWSR_POLL_BIT    7
`define FWSR_TOGGLE_BIT  6
`define FWSR_FAIL_BIT    5

// Reset command byte
`define FWSR_CMD_RESET   8'hf0

// Timing in ns, clock period in ns
`define FWSR_CLK_NS      5
`define FWSR_T_ACC_NS    150
`define FWSR_T_GAP_NS    20
`define FWSR_T_WP_NS     35

`endif

// File: src/fwsr_pkg.sv
package fwsr_pkg;

  typedef enum logic [3:0] {
    FWSR_IDLE = 4'b0001,
    FWSR_RD   = 4'b0010,
    FWSR_GAP  = 4'b0100,
    FWSR_WR   = 4'b1000
  } fwsr_state_e;

  typedef struct packed {
    fwsr_state_e st;
    logic [5:0]  cnt;
    logic        toggle_mode;
    logic        erase;
    logic [18:0] poll_addr;
    logic [7:0]  expect_data;
    logic        busy;
    logic        done;
    logic        fail;
    logic        first;
    logic        recheck;
    logic        final_rd;
    logic        prev6;
    logic [1:0]  nreads;
    logic [7:0]  rdata;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        dq_oe_n;
    logic [7:0]  dq_out;
    logic [18:0] addr;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } fwsr_state_s;

endpackage

// File: src/fwsr_host.sv
// Functional notes
// - Host polls the completion bit at the address being programmed.
// - Host polls erase status at an address inside a selected sector.
// - Poll bit may change alone; after true data take data on later reads.
// - Host re-reads the poll bit after seeing the timing failure bit set.
// - Host reads status twice and compares; unchanged means finished.
// - Still toggling: check failure bit, recheck; toggling means reset command.
// - After pausing, host restarts the toggle check from its first step.
// - After any timing failure the host writes the reset command.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "fwsr_params.svh"

module fwsr_host #(
  parameter int T_ACC_NS = `FWSR_T_ACC_NS,
  parameter int T_GAP_NS = `FWSR_T_GAP_NS,
  parameter int T_WP_NS  = `FWSR_T_WP_NS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Flash pins
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic [18:0]      flash_addr,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe_n,
  input  wire logic [7:0]  flash_dq_in
);
  import fwsr_pkg::*;

  localparam logic [5:0] RD_CYC  = 6'((T_ACC_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS);
  localparam logic [5:0] GAP_CYC = 6'((T_GAP_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS);
  localparam logic [5:0] WP_CYC  = 6'((T_WP_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS);

  fwsr_state_s s;
  fwsr_state_s next_s;

  // Bit 7 value that means the operation is over: erased cells read 1
  function automatic logic poll_target(input logic erase, input logic [7:0] expect_data);
    return erase ? 1'b1 : expect_data[`FWSR_POLL_BIT];
  endfunction

  function automatic fwsr_state_s start_read(input fwsr_state_s x);
    fwsr_state_s y;
    y       = x;
    y.st    = FWSR_RD;
    y.cnt   = 6'h00;
    y.ce_n  = 1'b0;
    y.oe_n  = 1'b0;
    y.addr  = x.poll_addr;
    return y;
  endfunction

  logic access;
  logic matched;
  logic same6;
  assign access  = psel && penable && !s.pready;
  assign matched = s.rdata[`FWSR_POLL_BIT] == poll_target(s.erase, s.expect_data);
  assign same6   = s.rdata[`FWSR_TOGGLE_BIT] == s.prev6;

  always_comb begin
    next_s         = s;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    // Register bus; answer lands one cycle into the access phase
    if (access) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      unique case (paddr)
        `FWSR_OFF_CTRL: begin
          next_s.prdata = {29'h0, s.erase, s.toggle_mode, 1'b0};
          if (pwrite) begin
            next_s.toggle_mode = pwdata[`FWSR_CTRL_TOGGLE];
            next_s.erase       = pwdata[`FWSR_CTRL_ERASE];
            if (pwdata[`FWSR_CTRL_START]) begin
              // A start always begins at the first step, even over a running check
              next_s          = start_read(next_s);
              next_s.busy     = 1'b1;
              next_s.done     = 1'b0;
              next_s.fail     = 1'b0;
              next_s.first    = 1'b1;
              next_s.recheck  = 1'b0;
              next_s.final_rd = 1'b0;
              next_s.nreads   = 2'h0;
              next_s.we_n     = 1'b1;
              next_s.dq_oe_n  = 1'b1;
            end
          end
        end
        `FWSR_OFF_ADDR: begin
          next_s.prdata = {13'h0, s.poll_addr};
          if (pwrite && !s.busy) begin
            next_s.poll_addr = pwdata[18:0];
          end
        end
        `FWSR_OFF_EXPECT: begin
          next_s.prdata = {24'h0, s.expect_data};
          if (pwrite && !s.busy) begin
            next_s.expect_data = pwdata[7:0];
          end
        end
        `FWSR_OFF_STATUS: begin
          next_s.prdata = {16'h0, s.rdata, 4'h0, s.recheck, s.fail, s.done, s.busy};
        end
        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    // Flash side; a start on the bus above takes priority
    if (!(access && pwrite && paddr == `FWSR_OFF_CTRL && pwdata[`FWSR_CTRL_START])) begin
      unique case (s.st)
        FWSR_IDLE: begin
          next_s.cnt = 6'h00;
        end
        FWSR_RD: begin
          next_s.cnt = s.cnt + 6'h01;
          if (s.cnt == RD_CYC - 6'h01) begin
            next_s.rdata = flash_dq_in;
            next_s.ce_n  = 1'b1;
            next_s.oe_n  = 1'b1;
            next_s.cnt   = 6'h00;
            next_s.st    = FWSR_GAP;
            if (s.nreads != 2'h3) begin
              next_s.nreads = s.nreads + 2'h1;
            end
          end
        end
        FWSR_GAP: begin
          next_s.cnt = s.cnt + 6'h01;
          if (s.cnt == GAP_CYC - 6'h01) begin
            next_s = start_read(next_s);
            if (s.final_rd) begin
              // Byte of the read after the status settled is the array data
              next_s.st   = FWSR_IDLE;
              next_s.ce_n = 1'b1;
              next_s.oe_n = 1'b1;
              next_s.busy = 1'b0;
              next_s.done = 1'b1;
            end else if (!s.toggle_mode) begin
              if (matched) begin
                next_s.final_rd = 1'b1;
              end else if (s.recheck) begin
                next_s.st = FWSR_WR;
              end else if (s.rdata[`FWSR_FAIL_BIT]) begin
                next_s.recheck = 1'b1;
              end
            end else begin
              next_s.prev6 = s.rdata[`FWSR_TOGGLE_BIT];
              next_s.first = 1'b0;
              if (s.first) begin
                next_s.final_rd = 1'b0;
              end else if (same6) begin
                next_s.final_rd = 1'b1;
              end else if (s.recheck) begin
                next_s.st = FWSR_WR;
              end else if (s.rdata[`FWSR_FAIL_BIT]) begin
                next_s.recheck = 1'b1;
              end
            end
            if (next_s.st == FWSR_WR) begin
              // Failure leaves the device in status mode until it sees this command
              next_s.fail    = 1'b1;
              next_s.ce_n    = 1'b0;
              next_s.oe_n    = 1'b1;
              next_s.we_n    = 1'b0;
              next_s.dq_oe_n = 1'b0;
              next_s.dq_out  = `FWSR_CMD_RESET;
            end
          end
        end
        FWSR_WR: begin
          next_s.cnt = s.cnt + 6'h01;
          if (s.cnt == WP_CYC - 6'h01) begin
            next_s.st      = FWSR_IDLE;
            next_s.ce_n    = 1'b1;
            next_s.we_n    = 1'b1;
            next_s.dq_oe_n = 1'b1;
            next_s.busy    = 1'b0;
            next_s.done    = 1'b1;
          end
        end
        default: begin
          next_s.st = FWSR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s         <= '0;
      s.st      <= FWSR_IDLE;
      s.ce_n    <= 1'b1;
      s.oe_n    <= 1'b1;
      s.we_n    <= 1'b1;
      s.dq_oe_n <= 1'b1;
      s.first   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign prdata        = s.prdata;
  assign flash_ce_n    = s.ce_n;
  assign flash_oe_n    = s.oe_n;
  assign flash_we_n    = s.we_n;
  assign flash_addr    = s.addr;
  assign flash_dq_out  = s.dq_out;
  assign flash_dq_oe_n = s.dq_oe_n;

  sequence reset_write_s;
    !flash_we_n && !flash_dq_oe_n && flash_dq_out == `FWSR_CMD_RESET;
  endsequence

  // The re-read is the one launched in the same cycle as the decision
  sequence next_read_s;
    !flash_ce_n && !flash_oe_n;
  endsequence

  prog_poll_addr_a: assert property (@(posedge clk) disable iff (rst)
    (!flash_oe_n && !s.erase) |-> flash_addr == s.poll_addr)
    else $error("program status read at wrong address");

  erase_poll_addr_a: assert property (@(posedge clk) disable iff (rst)
    (!flash_oe_n && s.erase) |-> flash_addr == s.poll_addr && !flash_ce_n)
    else $error("erase status read outside chosen sector");

  data_reread_a: assert property (@(posedge clk) disable iff (rst)
    $rose(s.final_rd) |-> !s.done ##0 next_read_s ##1 !s.done)
    else $error("data taken without a following read");

  fail_reread_a: assert property (@(posedge clk) disable iff (rst)
    ($rose(s.recheck) && !s.toggle_mode) |-> !s.fail ##0 next_read_s)
    else $error("no re-read after failure bit");

  two_reads_a: assert property (@(posedge clk) disable iff (rst)
    ($rose(s.done) && s.toggle_mode && !s.fail) |-> s.nreads == 2'h3)
    else $error("toggle check finished on fewer than three reads");

  toggle_fail_a: assert property (@(posedge clk) disable iff (rst)
    $rose(s.fail) |-> $past(s.recheck) && !$past(s.final_rd))
    else $error("failure declared without recheck");

  restart_first_a: assert property (@(posedge clk) disable iff (rst)
    (access && pwrite && paddr == `FWSR_OFF_CTRL && pwdata[`FWSR_CTRL_START])
      |=> s.first && !s.recheck && !flash_oe_n && s.nreads == 2'h0)
    else $error("restart did not begin at first step");

  reset_cmd_a: assert property (@(posedge clk) disable iff (rst)
    $rose(s.fail) |-> reset_write_s [*2])
    else $error("reset command not written after failure");

  cmd_no_read_a: assert property (@(posedge clk) disable iff (rst)
    !flash_we_n |-> flash_oe_n && !flash_ce_n && !flash_dq_oe_n)
    else $error("command write overlaps a read");

  read_no_drive_a: assert property (@(posedge clk) disable iff (rst)
    !flash_oe_n |-> flash_we_n && flash_dq_oe_n)
    else $error("host drives data during a status read");

  done_after_final_a: assert property (@(posedge clk) disable iff (rst)
    ($rose(s.done) && !s.fail) |-> $past(s.final_rd))
    else $error("done without a data read after completion");

  recheck_on_fail_a: assert property (@(posedge clk) disable iff (rst)
    $rose(s.recheck) |-> s.rdata[`FWSR_FAIL_BIT])
    else $error("recheck without failure bit");

  toggle_first_a: assert property (@(posedge clk) disable iff (rst)
    (s.toggle_mode && s.first && s.st == FWSR_GAP) |=> !s.final_rd)
    else $error("toggle check ended on the first read");

  pready_pulse_a: assert property (@(posedge clk) disable iff (rst)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

endmodule

// File: testbench/fwsr_flash_model.sv
`timescale 1ns/100ps
module fwsr_flash_model (
  // Clock
  input  wire logic        clk,
  // Flash pins
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic [18:0] flash_addr,
  input  wire logic [7:0]  flash_dq_out,
  input  wire logic        flash_dq_oe_n,
  output logic [7:0]       flash_dq_in
);
  logic [7:0]  arr      = 8'h00;
  logic [7:0]  last     = 8'h00;
  logic [18:0] rd_addr  = '0;
  logic        erase    = 0;
  logic        fail     = 0;
  logic        tog      = 0;
  logic        tog2     = 0;
  logic        rd_prev  = 0;
  logic        rst_seen = 0;
  logic        susp     = 0;
  int          left     = 0;
  wire         rd       = !flash_ce_n && !flash_oe_n;
  wire         busy     = left > 0;

  // Remaining reads stand in for operation time, also for a protected target
  task automatic arm(input logic er, input int n, input logic f, input logic [7:0] d);
    erase = er;
    left = n;
    fail = f;
    arr = d;
    rst_seen = 0;
  endtask

  // A released bus shows the inverse of the last byte, never a stale copy
  // Poll bit of an erase reads 1 while the erase is suspended
  assign flash_dq_in = !rd ? ~last :
                       busy ? {erase ? susp : ~arr[7], tog, fail, 2'b00, tog2, arr[1:0]} :
                       arr;

  always @(posedge clk) begin
    if (rd) begin
      last <= flash_dq_in;
      rd_addr <= flash_addr;
    end
    if (rd_prev && !rd && busy) begin
      if (!susp) tog <= ~tog;
      if (erase) tog2 <= ~tog2;
      if (!fail && !susp) left <= left - 1;
    end
    if (!flash_we_n && !flash_ce_n && !flash_dq_oe_n && flash_dq_out == 8'hf0) begin
      left <= 0;
      fail <= 0;
      rst_seen <= 1;
    end
    rd_prev <= rd;
  end
endmodule

// File: testbench/tb.sv
`timescale 1ns/100ps
`include "fwsr_params.svh"
module tb;
  logic        clk     = 0;
  logic        rst     = 1;
  logic        psel    = 0;
  logic        penable = 0;
  logic        pwrite  = 0;
  logic [11:0] paddr   = '0;
  logic [31:0] pwdata  = '0;
  logic        pready, pslverr, ce_n, oe_n, we_n, dq_oe_n, e;
  logic [31:0] prdata, q;
  logic [18:0] fa;
  logic [7:0]  dq_out, dq_in;
  int          errors     = 0;
  int          num_checks = 0;

  always #2.5 clk = ~clk;

  // Shortest flash timings keep each read to one clock; the reset command write spans two
  fwsr_host #(.T_ACC_NS(5), .T_GAP_NS(5), .T_WP_NS(10)) fwsr_host_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_addr(fa), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in));

  fwsr_flash_model fwsr_flash_model_inst (
    .clk(clk), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(fa),
    .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      check("pready", 0, 1);
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask

  // Second ADDR write lands while busy and must not move the polled address
  task automatic run_op(input logic tgl, input logic er, input int n, input logic f,
                        input logic [7:0] arr, input logic [7:0] tgt, input logic [18:0] a);
    int k = 0;
    apb(1, `FWSR_OFF_ADDR, {13'h0, a});
    apb(1, `FWSR_OFF_EXPECT, {24'h0, tgt});
    fwsr_flash_model_inst.arm(er, n, f, arr);
    apb(1, `FWSR_OFF_CTRL, {29'h0, er, tgl, 1'b1});
    apb(1, `FWSR_OFF_ADDR, 32'h00000123);
    apb(0, `FWSR_OFF_STATUS, 0);
    if (!f) check("busy", q[0], 1);
    do begin
      apb(0, `FWSR_OFF_STATUS, 0);
      k++;
    end while (q[0] !== 1'b0 && k < 200);
    if (q[0] !== 1'b0) begin
      check("done wait", 0, 1);
      complete_run();
    end
    check("poll address", {13'h0, fwsr_flash_model_inst.rd_addr}, {13'h0, a});
  endtask

  task automatic t_idle;
    apb(0, `FWSR_OFF_STATUS, 0);
    check("status reset", q, 0);
    check("idle pins", {ce_n, oe_n, we_n, dq_oe_n}, 4'hf);
    apb(1, 12'h010, 32'hffffffff);
    check("unmapped err", e, 1);
    apb(0, 12'h010, 0);
    check("unmapped data", q, 0);
  endtask

  task automatic t_prog_poll;
    run_op(0, 0, 10, 0, 8'h5a, 8'h5a, 19'h4a5a5);
    check("prog poll status", q[15:0], 16'h5a02);
  endtask

  task automatic t_erase_poll;
    run_op(0, 1, 10, 0, 8'hff, 8'hff, 19'h70001);
    check("erase poll status", q[15:0], 16'hff02);
  endtask

  // Programming a 1 over a 0 never completes and ends in the failure bit
  task automatic t_poll_fail;
    run_op(0, 0, 1, 1, 8'h80, 8'h80, 19'h10203);
    check("poll fail status", q[3:0], 4'he);
    check("reset command", fwsr_flash_model_inst.rst_seen, 1);
  endtask

  task automatic t_toggle;
    run_op(1, 0, 10, 0, 8'h5a, 8'h00, 19'h00abc);
    check("toggle status", q[15:0], 16'h5a02);
  endtask

  task automatic t_toggle_fail;
    run_op(1, 1, 1, 1, 8'h00, 8'h00, 19'h2ffff);
    check("toggle fail status", q[3:0], 4'he);
    check("reset command", fwsr_flash_model_inst.rst_seen, 1);
  endtask

  // Suspended erase: poll bit reads 1 and the any-address bit freezes, so the check ends clean
  task automatic t_suspend;
    int k = 0;
    fwsr_flash_model_inst.arm(1, 10, 0, 8'h00);
    fwsr_flash_model_inst.susp = 1;
    apb(1, `FWSR_OFF_CTRL, 32'h00000007);
    do begin
      apb(0, `FWSR_OFF_STATUS, 0);
      k++;
    end while (q[0] !== 1'b0 && k < 20);
    if (q[0] !== 1'b0) begin
      check("suspend wait", 0, 1);
      complete_run();
    end
    check("suspend status", {q[15], q[3:0]}, 5'h12);
    fwsr_flash_model_inst.susp = 0;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_idle();
    t_prog_poll();
    t_erase_poll();
    t_poll_fail();
    t_toggle();
    t_toggle_fail();
    t_suspend();
    complete_run();
  end
endmodule
